// File: verilog/lvr_reset_seq.sv
// Reset sequencer: supply detectors, reset pin, watchdog, flags and cause bits.
// Assumes detector outputs and pin are asynchronous; registers on a plain strobe port.
`timescale 1ns/10ps
`include "lvr_regs.svh"

module lvr_reset_seq
  import lvr_pkg::*;
#(
  parameter int WARMUP_NS = `LVR_WARMUP_NS,
  parameter int INIT_CYCLES = `LVR_INIT_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_detector_option,
  input wire logic i_reset_pin_enable,
  input wire logic i_below_2v0,
  input wire logic i_below_2v4,
  input wire logic i_at_or_below_2v4,
  input wire logic i_at_or_below_3v6,
  input wire logic i_reset_pin_n,
  input wire logic i_wdt_overflow,
  input wire logic [`LVR_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_sys_reset,
  output logic o_init_regs,
  output logic o_pc_clear,
  output logic o_irq
);
  localparam int WARMUP_CYC = (WARMUP_NS + `LVR_CLK_NS - 1) / `LVR_CLK_NS;
  localparam int TMR_W = 16;

  lvr_state_t state_q;
  logic [3:0] sync_out;
  logic below_2v0_s, below_2v4_s, mid_s, high_s, pin_n_s;
  logic pin_en, supply_low, pin_low, tmr_start, tmr_busy, tmr_done, hold_to_init;
  logic [TMR_W-1:0] tmr_count;
  logic mid_flag_q, high_flag_q;
  logic [1:0] cause_q;
  logic [2:0] alu_flags_q;
  logic [`LVR_IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_evt;
  logic pin_en_q;
  logic wr_program_flag_register, wr_stat, wr_mask, wr_ctrl;

  function automatic logic addr_hit(input logic [`LVR_ADDR_W-1:0] a,
    input logic [`LVR_ADDR_W-1:0] r);
    addr_hit = (a == r);
  endfunction

  // Detector outputs sync; pin idles high so no false reset at start
  lvr_sync2 #(.WIDTH(4), .INIT(4'h0)) u_sync_det (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_below_2v0, i_below_2v4, i_at_or_below_2v4, i_at_or_below_3v6}),
    .o_sync(sync_out)
  );
  lvr_sync2 #(.WIDTH(1), .INIT(1'b1)) u_sync_pin (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_reset_pin_n),
    .o_sync(pin_n_s)
  );
  assign {below_2v0_s, below_2v4_s, mid_s, high_s} = sync_out;

  // Only the build option gates the pin; the control bit is storage only
  assign pin_en = i_reset_pin_enable;
  assign pin_low = pin_en & ~pin_n_s;
  // 2.0V detector always resets; 2.4V reset only with highest option
  assign supply_low = below_2v0_s |
    ((i_detector_option == 2'(LVR_OPT_HIGHEST)) & below_2v4_s);

  // Every entry into INIT must load the timer, or the sequence stalls there
  assign hold_to_init = ~supply_low & ~pin_low &
    (((state_q == LVR_ST_HOLD) & ~pin_en) | (i_wdt_overflow & (state_q == LVR_ST_RUN)));
  assign tmr_count = (state_q == LVR_ST_INIT) ? TMR_W'(WARMUP_CYC) : TMR_W'(INIT_CYCLES);
  assign tmr_start = ((state_q == LVR_ST_PIN_WAIT) & pin_n_s) | hold_to_init |
    ((state_q == LVR_ST_INIT) & tmr_done);

  lvr_cycle_timer #(.WIDTH(TMR_W)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(tmr_start),
    .i_count(tmr_count),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // Sequence; supply low always returns to hold, pin low goes to pin wait
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      state_q <= LVR_ST_HOLD;
    else if (supply_low)
      state_q <= LVR_ST_HOLD;
    else if (pin_low)
      state_q <= LVR_ST_PIN_WAIT;
    else if (i_wdt_overflow && state_q == LVR_ST_RUN)
      state_q <= LVR_ST_INIT;
    else
    begin
      case (state_q)
        LVR_ST_HOLD: state_q <= pin_en ? LVR_ST_PIN_WAIT : LVR_ST_INIT;
        LVR_ST_PIN_WAIT: if (pin_n_s) state_q <= LVR_ST_INIT;
        LVR_ST_INIT: if (tmr_done) state_q <= LVR_ST_WARMUP;
        LVR_ST_WARMUP: if (tmr_done) state_q <= LVR_ST_RUN;
        LVR_ST_RUN: state_q <= LVR_ST_RUN;
        default: state_q <= LVR_ST_HOLD;
      endcase
    end
  end

  assign o_sys_reset = (state_q != LVR_ST_RUN);
  assign o_init_regs = (state_q == LVR_ST_INIT);
  assign o_pc_clear = (state_q != LVR_ST_RUN);

  // Supply flags: gated by option, cleared during supply reset
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || supply_low)
    begin
      mid_flag_q <= 1'b0;
      high_flag_q <= 1'b0;
    end
    else
    begin
      mid_flag_q <= (i_detector_option != 2'(LVR_OPT_LOWEST)) & mid_s;
      high_flag_q <= (i_detector_option == 2'(LVR_OPT_HIGHEST)) & high_s;
    end
  end

  // Cause bits; power beats pin beats watchdog
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || supply_low)
      cause_q <= `LVR_CAUSE_POR;
    else if (pin_low)
      cause_q <= `LVR_CAUSE_EXT;
    else if (i_wdt_overflow && state_q == LVR_ST_RUN)
      cause_q <= `LVR_CAUSE_WDT;
    else if (wr_program_flag_register && cause_q != `LVR_CAUSE_POR && i_wdata[7:6] != 2'h1)
      cause_q <= i_wdata[7:6];
  end

  assign wr_program_flag_register = i_wr & addr_hit(i_addr, `LVR_ADDR_PROGRAM_FLAG_REGISTER) & (state_q == LVR_ST_RUN);
  assign wr_ctrl = i_wr & addr_hit(i_addr, `LVR_ADDR_CTRL);
  assign wr_stat = i_wr & addr_hit(i_addr, `LVR_ADDR_IRQ_STAT);
  assign wr_mask = i_wr & addr_hit(i_addr, `LVR_ADDR_IRQ_MASK);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || o_init_regs)
      alu_flags_q <= 3'h0;
    else if (wr_program_flag_register)
      alu_flags_q <= 3'(i_wdata & `LVR_PROGRAM_FLAG_REGISTER_RW_MASK);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      pin_en_q <= 1'b0;
    else if (wr_ctrl)
      pin_en_q <= i_wdata[0];
  end

  // Events survive reset sequence so software sees them after boot
  assign irq_evt[`LVR_IRQ_POR] = supply_low & (state_q != LVR_ST_HOLD);
  assign irq_evt[`LVR_IRQ_WDT] = i_wdt_overflow & (state_q == LVR_ST_RUN);
  assign irq_evt[`LVR_IRQ_EXT] = pin_low & (state_q != LVR_ST_PIN_WAIT);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? i_wdata[`LVR_IRQ_W-1:0] : '0)) | irq_evt;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      irq_mask_q <= '0;
    else if (wr_mask)
      irq_mask_q <= i_wdata[`LVR_IRQ_W-1:0];
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        `LVR_ADDR_PROGRAM_FLAG_REGISTER: o_rdata <= {cause_q, high_flag_q, mid_flag_q, 1'b0, alu_flags_q};
        `LVR_ADDR_CTRL: o_rdata <= {7'h00, pin_en_q};
        `LVR_ADDR_IRQ_STAT: o_rdata <= {5'h00, irq_stat_q};
        `LVR_ADDR_IRQ_MASK: o_rdata <= {5'h00, irq_mask_q};
        default: o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end

  chk_lowest_flags: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_detector_option == 2'(LVR_OPT_LOWEST) |=> !high_flag_q && !mid_flag_q)
    else $error("flags set in lowest option");
  chk_mid_track: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_detector_option == 2'(LVR_OPT_MIDDLE) && !supply_low && mid_s) |=> mid_flag_q)
    else $error("mid flag not tracking");
  chk_high_reset: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_detector_option == 2'(LVR_OPT_HIGHEST) && below_2v4_s) |=> state_q == LVR_ST_HOLD)
    else $error("2.4V reset missing");
  chk_high_flag: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_detector_option == 2'(LVR_OPT_HIGHEST) && !supply_low && high_s) |=> high_flag_q)
    else $error("high flag not tracking");
  chk_por_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    below_2v0_s |=> o_sys_reset && cause_q == `LVR_CAUSE_POR)
    else $error("2.0V reset missing");
  chk_flag_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    supply_low |=> !mid_flag_q && !high_flag_q)
    else $error("flags not cleared");
  chk_pin_ignored: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (!pin_en && state_q == LVR_ST_RUN && !supply_low && !i_wdt_overflow)
      |=> state_q == LVR_ST_RUN)
    else $error("disabled pin caused reset");
  chk_warmup_timer: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    state_q == LVR_ST_WARMUP |-> tmr_busy || tmr_done)
    else $error("warm-up without timer");
  chk_pin_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (pin_low && !supply_low) |=> state_q == LVR_ST_PIN_WAIT && o_sys_reset)
    else $error("pin low not holding reset");
  chk_wdt_cause: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (state_q == LVR_ST_RUN && i_wdt_overflow && !supply_low && !pin_low)
      |=> state_q == LVR_ST_INIT && cause_q == `LVR_CAUSE_WDT)
    else $error("watchdog reset wrong");
  chk_init_order: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (state_q == LVR_ST_INIT && $past(state_q) != LVR_ST_INIT) |-> ##[1:40] state_q != LVR_ST_INIT)
    else $error("init stage stuck");

  cov_wdt: cover property (@(posedge i_sys_clk) state_q == LVR_ST_RUN ##1 state_q == LVR_ST_INIT);
  cov_pin: cover property (@(posedge i_sys_clk) state_q == LVR_ST_PIN_WAIT ##1 state_q == LVR_ST_INIT);
  cov_boot: cover property (@(posedge i_sys_clk) state_q == LVR_ST_WARMUP ##1 state_q == LVR_ST_RUN);
endmodule

// File: verilog/lvr_regs.svh
// Register map, field positions, cause codes, interrupt bits and timing counts of the reset sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef LVR_REGS_SVH
`define LVR_REGS_SVH
`define LVR_ADDR_W 8
`define LVR_ADDR_PROGRAM_FLAG_REGISTER 8'h86
`define LVR_ADDR_CTRL 8'h90
`define LVR_ADDR_IRQ_STAT 8'h91
`define LVR_ADDR_IRQ_MASK 8'h92
`define LVR_BIT_TIMEOUT 7
`define LVR_BIT_PWRDN 6
`define LVR_BIT_HIGH_FLAG 5
`define LVR_BIT_MID_FLAG 4
`define LVR_PROGRAM_FLAG_REGISTER_RW_MASK 8'h07
`define LVR_CAUSE_WDT 2'h0
`define LVR_CAUSE_POR 2'h2
`define LVR_CAUSE_EXT 2'h3
`define LVR_IRQ_W 3
`define LVR_IRQ_POR 0
`define LVR_IRQ_WDT 1
`define LVR_IRQ_EXT 2
`define LVR_INIT_CYCLES 16
`define LVR_WARMUP_NS 4000
`define LVR_CLK_NS 40
`endif

// File: verilog/lvr_pkg.sv
// Types shared by the reset sequencer files.
// Assumes lvr_regs.svh is on the include path.
package lvr_pkg;
  typedef enum logic [1:0] {LVR_OPT_LOWEST, LVR_OPT_MIDDLE, LVR_OPT_HIGHEST} lvr_opt_t;
  typedef enum {LVR_ST_HOLD, LVR_ST_PIN_WAIT, LVR_ST_INIT, LVR_ST_WARMUP, LVR_ST_RUN} lvr_state_t;
endpackage

// File: verilog/lvr_sync2.sv
// Two-stage synchroniser for a bus of asynchronous levels.
// Assumes only the second stage is consumed.
`timescale 1ns/10ps
module lvr_sync2 #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      meta_q <= INIT;
      o_sync <= INIT;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// File: verilog/lvr_cycle_timer.sv
// Loadable down-counter that pulses o_done when it expires.
// Assumes i_start is a one-cycle pulse.
`timescale 1ns/10ps
module lvr_cycle_timer #(
  parameter int WIDTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_busy,
  output logic o_done
);
  logic [WIDTH-1:0] cnt_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      cnt_q <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        cnt_q <= i_count;
        o_busy <= 1'b1;
      end
      else if (o_busy)
      begin
        if (cnt_q <= WIDTH'(1))
        begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        else
          cnt_q <= cnt_q - WIDTH'(1);
      end
    end
  end
endmodule

// File: test/lvr_ext_reset_model.sv
// External reset circuit model driving the active-low reset pin.
// Assumes a power-good level and a push-button request from the bench.
`timescale 1ns/10ps
module lvr_ext_reset_model #(
  parameter int RISE_CYCLES = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_power_good,
  input wire logic i_press,
  output logic o_reset_pin_n
);
  int count_q = 0;
  // RC delay holds the pin low after power-up, so boot must wait for it
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_power_good)
      count_q <= 0;
    else if (count_q < RISE_CYCLES)
      count_q <= count_q + 1;
  end
  assign o_reset_pin_n = i_power_good && (count_q >= RISE_CYCLES) && !i_press;
endmodule

// File: test/test_lvr_reset_seq.sv
// Self-checking bench for the reset sequencer.
// Assumes short init and warm-up counts set through parameters.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_lvr_reset_seq;
  logic clk = 0, rst = 1, pin_en = 1, b20 = 0, b24 = 0, a24 = 0, a36 = 0, wdt = 0;
  logic bus_wr = 0, bus_rd = 0, pgood = 0, press = 0, pin_n, sys_reset, init_regs, pc_clear, irq;
  logic saw_init = 0;
  logic [1:0] opt = 2'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  int miscompares = 0, checks_done = 0;
  always #20 clk = ~clk;
  always @(posedge clk)
    if (init_regs === 1'b1)
      saw_init <= 1'b1;
  lvr_ext_reset_model pin_model (.i_sys_clk(clk), .i_power_good(pgood), .i_press(press),
    .o_reset_pin_n(pin_n));
  lvr_reset_seq #(.WARMUP_NS(200), .INIT_CYCLES(2)) dut (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_detector_option(opt), .i_reset_pin_enable(pin_en), .i_below_2v0(b20),
    .i_below_2v4(b24), .i_at_or_below_2v4(a24), .i_at_or_below_3v6(a36),
    .i_reset_pin_n(pin_n), .i_wdt_overflow(wdt), .i_addr(addr), .i_wdata(wdata),
    .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata), .o_sys_reset(sys_reset),
    .o_init_regs(init_regs), .o_pc_clear(pc_clear), .o_irq(irq));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Two sync stages plus one state edge, with margin
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (sys_reset !== 1'b0 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask
  task automatic t_power();
    repeat (5) @(posedge clk);
    #1 `CHK("held_by_pin", 1'b1, sys_reset)
    wait_run();
    `CHK("run", 1'b0, sys_reset)
    `CHK("pc_clear", 1'b0, pc_clear)
    `CHK("saw_init", 1'b1, saw_init)
    $display("test power done");
  endtask
  task automatic t_flags();
    for (int o = 0; o < 3; o++)
    begin
      opt <= o[1:0];
      a24 <= 1'b1;
      a36 <= 1'b1;
      settle();
      rd(8'h86);
      `CHK("flags", {o == 2, o != 0}, v[5:4])
      a24 <= 1'b0;
      a36 <= 1'b0;
      settle();
      rd(8'h86);
      `CHK("flags_off", 2'h0, v[5:4])
    end
    wr(8'h86, 8'hFF);
    rd(8'h86);
    `CHK("program_flag_register_rw", 8'h07, v & 8'h3F)
    $display("test flags done");
  endtask
  task automatic t_supply();
    opt <= 2'h2;
    a24 <= 1'b1;
    a36 <= 1'b1;
    b24 <= 1'b1;
    settle();
    `CHK("rst_2v4", 1'b1, sys_reset)
    rd(8'h86);
    `CHK("cause_flags", 4'h8, v[7:4])
    b24 <= 1'b0;
    wait_run();
    opt <= 2'h1;
    b24 <= 1'b1;
    settle();
    `CHK("mid_no_rst", 1'b0, sys_reset)
    rd(8'h86);
    `CHK("mid_flags", 2'h1, v[5:4])
    opt <= 2'h0;
    b24 <= 1'b0;
    b20 <= 1'b1;
    settle();
    `CHK("rst_2v0", 1'b1, sys_reset)
    b20 <= 1'b0;
    wait_run();
    `CHK("run_again", 1'b0, sys_reset)
    $display("test supply done");
  endtask
  task automatic t_wdt();
    wr(8'h92, 8'h02);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    #1 `CHK("wdt_rst", 1'b1, sys_reset)
    wait_run();
    `CHK("wdt_run", 1'b0, sys_reset)
    rd(8'h86);
    `CHK("cause_wdt", 2'h0, v[7:6])
    `CHK("irq_on", 1'b1, irq)
    wr(8'h91, 8'h02);
    settle();
    `CHK("irq_off", 1'b0, irq)
    rd(8'h55);
    `CHK("unmapped", 8'h00, v)
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    b20 <= 1'b1;
    repeat (150) @(posedge clk);
    #1 `CHK("wdt_low", 1'b1, sys_reset)
    b20 <= 1'b0;
    wait_run();
    `CHK("wdt_low_run", 1'b0, sys_reset)
    $display("test watchdog done");
  endtask
  task automatic t_pin();
    press <= 1'b1;
    settle();
    `CHK("pin_rst", 1'b1, sys_reset)
    repeat (20) @(posedge clk);
    #1 `CHK("pin_wait", 1'b1, sys_reset)
    press <= 1'b0;
    wait_run();
    `CHK("pin_run", 1'b0, sys_reset)
    rd(8'h86);
    `CHK("cause_pin", 2'h3, v[7:6])
    pin_en <= 1'b0;
    wr(8'h90, 8'h01);
    press <= 1'b1;
    settle();
    `CHK("pin_off", 1'b0, sys_reset)
    press <= 1'b0;
    $display("test pin done");
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Whole run needs a few hundred cycles; the limit leaves ample margin
  initial
  begin
    #800000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    pgood <= 1'b1;
    t_power();
    t_flags();
    t_supply();
    t_wdt();
    t_pin();
    give_verdict();
  end
endmodule
